// file: hdl/phase_timer.sv
// Timer for the high and low phases of the bus clock
module phase_timer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic sel_high,
   input wire two_wire_pkg::clock_cfg_type clock_cfg,
   // Phase elapsed, one cycle
   output logic done
);

   logic [17:0] cnt_q;
   logic [17:0] len;

   // Phase length is the divider scaled by the common power of two, plus PHASE_OFFSET
   always_comb begin
      len = (18'(sel_high ? clock_cfg.high : clock_cfg.low)
             << clock_cfg.common) + two_wire_pkg::PHASE_OFFSET;
   end

   assign done = run && (cnt_q == len - 18'h00001);

   // Dropping run restarts the count, so a stretched clock restarts it too
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 18'h00000;
      end else if (!run || done) begin
         cnt_q <= 18'h00000;
      end else begin
         cnt_q <= cnt_q + 18'h00001;
      end
   end

endmodule : phase_timer

// file: hdl/pin_sync.sv
// Two-flop synchroniser for the bus line inputs
module pin_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Lines
   input wire logic [WIDTH-1:0] pins_in,
   output logic [WIDTH-1:0] pins_sync
);

   logic [WIDTH-1:0] meta_q;

   // Both stages reset to the idle bus level so no false START is seen
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {WIDTH{two_wire_pkg::BUS_IDLE_LEVEL}};
         pins_sync <= {WIDTH{two_wire_pkg::BUS_IDLE_LEVEL}};
      end else begin
         meta_q <= pins_in;
         pins_sync <= meta_q;
      end
   end

endmodule : pin_sync

// file: hdl/two_wire_bus_master.sv
// Two-wire bus master: byte sequencer, holding registers and status flags
// Functional notes
// - Bytes are eight bits, MSB first, each followed by an acknowledge bit.
// - START is data falling with clock high; STOP is data rising.
// - Writing transmit data starts: START, 7-bit address, direction bit 0.
// - Master releases data on the ninth pulse so the slave can acknowledge.
// - Unacknowledged byte sets the nack flag and then sends STOP.
// - Status read clears nack; software reads before next transmit write.
// - Any enabled status flag raises the interrupt line.
// - On acknowledge, held byte moves to shifter; transmit-free set until write.
// - Transmit-free and receive-waiting flags are the DMA request lines.
// - After a write byte, clock held low until new data or STOP.
// - STOP command makes the master issue a STOP condition.
// - START command in read mode: START, 7-bit address, direction bit 1.
// - Address acknowledge sampled in read mode; missing acknowledge sets nack.
// - Master acknowledges each received byte except the last one.
// - Receive-waiting set when byte lands, cleared by reading it.
// - Full receive register stalls clock before last bit until read.
// - Internal address read writes address bytes, repeated START, then reads.
// - Internal address size selects zero to three address bytes.
module two_wire_bus_master (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Bus lines, open drain: oe high pulls the line low
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   // Control commands, one-cycle pulses
   input wire logic master_enable_cmd,
   input wire logic master_disable_cmd,
   input wire logic start_cmd,
   input wire logic stop_cmd,
   // Master mode settings
   input wire logic [6:0] target_device_address,
   input wire logic read_direction_bit,
   input wire logic [1:0] internal_address_size,
   input wire logic [23:0] internal_address_bytes,
   input wire two_wire_pkg::clock_cfg_type clock_cfg,
   // Transmit holding register
   input wire logic [7:0] thr_data,
   input wire logic thr_write,
   // Receive holding register
   output logic [7:0] rhr_data,
   input wire logic rhr_read,
   // Status and interrupt
   output two_wire_pkg::status_type status,
   input wire logic status_read,
   input wire two_wire_pkg::status_type irq_enable,
   output logic irq,
   // DMA requests
   output logic dma_tx_req,
   output logic dma_rx_req
);

   two_wire_pkg::state_type state_q;
   two_wire_pkg::kind_type kind_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] sh_q;
   logic [7:0] thr_q;
   logic [1:0] internal_address_bytes_left_q;
   logic read_op_q;
   logic rx_ack_q;
   logic master_on_q;
   logic thr_full_q;
   logic stop_req_q;
   logic transmit_slot_free_q;
   logic receive_byte_waiting_q;
   logic nack_q;
   logic scl_d;
   logic sda_d;
   logic data_drive;
   logic scl_s;
   logic sda_s;
   logic t_run;
   logic t_high;
   logic t_done;
   logic go_write;
   logic go_read;
   logic byte_end;
   logic nack_set;
   logic tx_set;
   logic rx_set;
   logic thr_take;

   // Picks one internal address byte, most significant byte sent first
   function automatic logic [7:0] internal_address_bytes_byte(input logic [23:0] b,
                                            input logic [1:0] idx);
      case (idx)
         2'h2: internal_address_bytes_byte = b[23:16];
         2'h1: internal_address_bytes_byte = b[15:8];
         default: internal_address_bytes_byte = b[7:0];
      endcase
   endfunction : internal_address_bytes_byte

   ////////////////////////////////////////////////////////////////////////
   // Line synchroniser and phase timer

   pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .pins_in({serial_clock_pin_in, serial_data_pin_in}),
      .pins_sync({scl_s, sda_s})
   );

   phase_timer u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(t_run),
      .sel_high(t_high),
      .clock_cfg(clock_cfg),
      .done(t_done)
   );

   // High phases only count once the line is seen high: slave stretching
   always_comb begin
      t_high = state_q inside {two_wire_pkg::ST_START, two_wire_pkg::ST_START2,
         two_wire_pkg::ST_HIGH, two_wire_pkg::ST_STOP_HIGH,
         two_wire_pkg::ST_STOP_END};
      t_run = (t_high && scl_s) || state_q inside {two_wire_pkg::ST_LOW,
         two_wire_pkg::ST_STOP_LOW, two_wire_pkg::ST_RS_LOW};
   end

   ////////////////////////////////////////////////////////////////////////
   // Events

   assign go_write = (state_q == two_wire_pkg::ST_IDLE) && master_on_q
      && thr_write && !read_direction_bit;
   assign go_read = (state_q == two_wire_pkg::ST_IDLE) && master_on_q
      && start_cmd && read_direction_bit;
   assign byte_end = (state_q == two_wire_pkg::ST_HIGH) && t_done
      && (bit_cnt_q == two_wire_pkg::BIT_ACK);
   // Address bytes of both directions are checked for acknowledge
   assign nack_set = byte_end && sda_s
      && (kind_q != two_wire_pkg::K_RX);
   // Acknowledge of the byte that precedes a transmit data slot
   assign tx_set = byte_end && !sda_s && ((kind_q == two_wire_pkg::K_TX)
      || ((kind_q != two_wire_pkg::K_RX) && (internal_address_bytes_left_q == 2'h0)
      && !read_op_q));
   assign rx_set = (state_q == two_wire_pkg::ST_HIGH) && t_done
      && (kind_q == two_wire_pkg::K_RX)
      && (bit_cnt_q == two_wire_pkg::BIT_LAST);
   // Holding byte moves to the shifter; tied to the load itself, since a
   // data compare could match a byte written while the shifter still runs
   assign thr_take = thr_full_q && (kind_q != two_wire_pkg::K_RX)
      && ((state_q == two_wire_pkg::ST_HOLD) || (byte_end && !nack_set
      && !read_op_q && !((kind_q != two_wire_pkg::K_TX)
      && (internal_address_bytes_left_q != 2'h0))));

   ////////////////////////////////////////////////////////////////////////
   // Byte sequencer

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= two_wire_pkg::ST_IDLE;
         kind_q <= two_wire_pkg::K_ADDR;
         bit_cnt_q <= two_wire_pkg::BIT_FIRST;
         sh_q <= 8'h00;
         internal_address_bytes_left_q <= 2'h0;
         read_op_q <= 1'b0;
         rx_ack_q <= 1'b0;
         rhr_data <= 8'h00;
      end else begin
         case (state_q)
            two_wire_pkg::ST_IDLE: begin
               if (go_write || go_read) begin
                  // With address bytes the first address always writes
                  sh_q <= {target_device_address, (internal_address_size
                     == 2'h0) ? read_direction_bit : 1'b0};
                  internal_address_bytes_left_q <= internal_address_size;
                  read_op_q <= read_direction_bit;
                  kind_q <= two_wire_pkg::K_ADDR;
                  state_q <= two_wire_pkg::ST_START;
               end
            end
            two_wire_pkg::ST_START: begin
               if (t_done) begin
                  state_q <= two_wire_pkg::ST_START2;
               end
            end
            two_wire_pkg::ST_START2: begin
               if (t_done) begin
                  bit_cnt_q <= two_wire_pkg::BIT_FIRST;
                  state_q <= two_wire_pkg::ST_LOW;
               end
            end
            two_wire_pkg::ST_LOW: begin
               if (t_done) begin
                  if (kind_q == two_wire_pkg::K_RX && receive_byte_waiting_q
                      && bit_cnt_q == two_wire_pkg::BIT_LAST) begin
                     state_q <= two_wire_pkg::ST_HOLD;
                  end else begin
                     state_q <= two_wire_pkg::ST_HIGH;
                  end
               end
            end
            two_wire_pkg::ST_HIGH: begin
               if (t_done && bit_cnt_q != two_wire_pkg::BIT_ACK) begin
                  // Shift MSB first; received bits enter at the bottom
                  sh_q <= {sh_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  state_q <= two_wire_pkg::ST_LOW;
                  if (rx_set) begin
                     rhr_data <= {sh_q[6:0], sda_s};
                     rx_ack_q <= !stop_req_q;
                  end
               end else if (byte_end) begin
                  bit_cnt_q <= two_wire_pkg::BIT_FIRST;
                  if (nack_set) begin
                     state_q <= two_wire_pkg::ST_STOP_LOW;
                  end else if (kind_q == two_wire_pkg::K_RX) begin
                     state_q <= rx_ack_q ? two_wire_pkg::ST_LOW
                        : two_wire_pkg::ST_STOP_LOW;
                  end else if (kind_q != two_wire_pkg::K_TX
                               && internal_address_bytes_left_q != 2'h0) begin
                     // Also carries the low byte of a ten-bit address
                     sh_q <= internal_address_bytes_byte(internal_address_bytes,
                        internal_address_bytes_left_q - 2'h1);
                     internal_address_bytes_left_q <= internal_address_bytes_left_q - 2'h1;
                     kind_q <= two_wire_pkg::K_INTERNAL_ADDRESS_BYTES;
                     state_q <= two_wire_pkg::ST_LOW;
                  end else if (read_op_q
                               && kind_q == two_wire_pkg::K_ADDR) begin
                     kind_q <= two_wire_pkg::K_RX;
                     state_q <= two_wire_pkg::ST_LOW;
                  end else if (read_op_q) begin
                     state_q <= two_wire_pkg::ST_RS_LOW;
                  end else if (thr_full_q) begin
                     sh_q <= thr_q;
                     kind_q <= two_wire_pkg::K_TX;
                     state_q <= two_wire_pkg::ST_LOW;
                  end else if (stop_req_q) begin
                     state_q <= two_wire_pkg::ST_STOP_LOW;
                  end else begin
                     kind_q <= two_wire_pkg::K_TX;
                     bit_cnt_q <= two_wire_pkg::BIT_ACK;
                     state_q <= two_wire_pkg::ST_HOLD;
                  end
               end
            end
            two_wire_pkg::ST_HOLD: begin
               if (kind_q == two_wire_pkg::K_RX) begin
                  if (!receive_byte_waiting_q) begin
                     state_q <= two_wire_pkg::ST_HIGH;
                  end
               end else if (thr_full_q) begin
                  sh_q <= thr_q;
                  bit_cnt_q <= two_wire_pkg::BIT_FIRST;
                  state_q <= two_wire_pkg::ST_LOW;
               end else if (stop_req_q) begin
                  state_q <= two_wire_pkg::ST_STOP_LOW;
               end
            end
            two_wire_pkg::ST_RS_LOW: begin
               if (t_done) begin
                  sh_q <= {target_device_address, 1'b1};
                  kind_q <= two_wire_pkg::K_ADDR;
                  state_q <= two_wire_pkg::ST_START;
               end
            end
            two_wire_pkg::ST_STOP_LOW: begin
               if (t_done) begin
                  state_q <= two_wire_pkg::ST_STOP_HIGH;
               end
            end
            two_wire_pkg::ST_STOP_HIGH: begin
               if (t_done) begin
                  state_q <= two_wire_pkg::ST_STOP_END;
               end
            end
            two_wire_pkg::ST_STOP_END: begin
               if (t_done) begin
                  state_q <= two_wire_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= two_wire_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line drive

   // Ninth pulse: released on write, driven by our acknowledge on read
   always_comb begin
      if (bit_cnt_q != two_wire_pkg::BIT_ACK) begin
         data_drive = (kind_q != two_wire_pkg::K_RX) && !sh_q[7];
      end else begin
         data_drive = (kind_q == two_wire_pkg::K_RX) && rx_ack_q;
      end
   end

   always_comb begin
      scl_d = 1'b0;
      sda_d = 1'b0;
      case (state_q)
         two_wire_pkg::ST_START2: sda_d = 1'b1;
         two_wire_pkg::ST_LOW, two_wire_pkg::ST_HOLD: begin
            scl_d = 1'b1;
            sda_d = data_drive;
         end
         two_wire_pkg::ST_HIGH: sda_d = data_drive;
         two_wire_pkg::ST_STOP_LOW: begin
            scl_d = 1'b1;
            sda_d = 1'b1;
         end
         two_wire_pkg::ST_STOP_HIGH: sda_d = 1'b1;
         two_wire_pkg::ST_RS_LOW: scl_d = 1'b1;
         default: ;
      endcase
   end

   // Data waits one cycle after clock is pulled, so it never moves on a high
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         serial_clock_pin_oe <= 1'b0;
         serial_data_pin_oe <= 1'b0;
      end else begin
         serial_clock_pin_oe <= scl_d;
         if (serial_clock_pin_oe || !scl_d) begin
            serial_data_pin_oe <= sda_d;
         end
      end
   end

   assign serial_clock_pin_out = 1'b0;
   assign serial_data_pin_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Master enable and holding register

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         master_on_q <= 1'b0;
      end else if (master_enable_cmd) begin
         master_on_q <= 1'b1;
      end else if (master_disable_cmd) begin
         master_on_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         thr_q <= 8'h00;
         thr_full_q <= 1'b0;
      end else if (thr_write) begin
         thr_q <= thr_data;
         thr_full_q <= 1'b1;
      end else if (thr_take) begin
         thr_full_q <= 1'b0;
      end
   end

   // STOP with START in one write flags the first byte as the last
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stop_req_q <= 1'b0;
      end else if (stop_cmd && master_on_q) begin
         stop_req_q <= 1'b1;
      end else if (state_q == two_wire_pkg::ST_STOP_END) begin
         stop_req_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags: a set in the same cycle as a clear wins

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         transmit_slot_free_q <= two_wire_pkg::TX_READY_RESET;
      end else begin
         transmit_slot_free_q <= tx_set || (transmit_slot_free_q && !thr_write);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         receive_byte_waiting_q <= 1'b0;
      end else begin
         receive_byte_waiting_q <= rx_set || (receive_byte_waiting_q && !rhr_read);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         nack_q <= 1'b0;
      end else begin
         nack_q <= nack_set || (nack_q && !status_read);
      end
   end

   always_comb begin
      status.tx_complete = (state_q == two_wire_pkg::ST_IDLE);
      status.nack = nack_q;
      status.receive_byte_waiting = receive_byte_waiting_q;
      status.transmit_slot_free = transmit_slot_free_q;
   end

   assign irq = |(status & irq_enable);
   assign dma_tx_req = transmit_slot_free_q;
   assign dma_rx_req = receive_byte_waiting_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence start_fall;
      (state_q == two_wire_pkg::ST_START) && t_done
      ##1 state_q == two_wire_pkg::ST_START2;
   endsequence

   sequence stop_rise;
      (state_q == two_wire_pkg::ST_STOP_HIGH) && t_done
      ##1 state_q == two_wire_pkg::ST_STOP_END;
   endsequence

   a_start_shape: assert property (
      start_fall |=> !serial_clock_pin_oe && serial_data_pin_oe)
      else $error("START does not pull data with clock released");

   a_stop_shape: assert property (
      stop_rise |=> !serial_clock_pin_oe && !serial_data_pin_oe)
      else $error("STOP does not release data with clock released");

   a_ack_release: assert property (
      (state_q == two_wire_pkg::ST_HIGH) && (kind_q != two_wire_pkg::K_RX)
      && (bit_cnt_q == two_wire_pkg::BIT_ACK) |-> !serial_data_pin_oe)
      else $error("Data line driven during slave acknowledge");

   a_nack_stop: assert property (
      nack_set |=> nack_q && state_q == two_wire_pkg::ST_STOP_LOW)
      else $error("Missing acknowledge not flagged or not stopped");

   a_nack_clear: assert property (
      status_read && !nack_set |=> !nack_q)
      else $error("Status read did not clear nack");

   a_transmit_slot_free_clear: assert property (
      thr_write && !tx_set |=> !status.transmit_slot_free && thr_full_q)
      else $error("Transmit slot not taken by write");

   a_tx_hold: assert property (
      state_q == two_wire_pkg::ST_HOLD |=> serial_clock_pin_oe)
      else $error("Clock not held low while waiting");

   a_rx_ack: assert property (
      (state_q == two_wire_pkg::ST_HIGH) && (kind_q == two_wire_pkg::K_RX)
      && (bit_cnt_q == two_wire_pkg::BIT_ACK)
      |-> serial_data_pin_oe == rx_ack_q)
      else $error("Receive acknowledge drive wrong");

   a_rx_flag: assert property (
      rx_set |=> receive_byte_waiting_q && rhr_data == {$past(sh_q[6:0]), $past(sda_s)})
      else $error("Received byte not posted");

   a_rx_stall: assert property (
      (state_q == two_wire_pkg::ST_HOLD) && (kind_q == two_wire_pkg::K_RX)
      && receive_byte_waiting_q |=> state_q == two_wire_pkg::ST_HOLD)
      else $error("Receive stall left while register full");

endmodule : two_wire_bus_master

// file: hdl/two_wire_pkg.sv
// Shared types and constants of the two-wire bus master
package two_wire_pkg;

   // Extra peripheral cycles added to every bus clock phase
   localparam logic [17:0] PHASE_OFFSET = 18'h00004;
   // Bit positions within one byte slot (eight data bits, then acknowledge)
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // Values after reset
   localparam logic TX_READY_RESET = 1'b1;
   localparam logic BUS_IDLE_LEVEL = 1'b1;

   // Clock waveform dividers
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic [2:0] common;
   } clock_cfg_type;

   // Status flags, also the layout of the interrupt enables
   typedef struct packed {
      logic tx_complete;
      logic nack;
      logic receive_byte_waiting;
      logic transmit_slot_free;
   } status_type;

   // Bus sequencer states
   typedef enum logic [9:0] {
      ST_IDLE      = 10'h001,
      ST_START     = 10'h002,
      ST_START2    = 10'h004,
      ST_LOW       = 10'h008,
      ST_HIGH      = 10'h010,
      ST_HOLD      = 10'h020,
      ST_STOP_LOW  = 10'h040,
      ST_STOP_HIGH = 10'h080,
      ST_STOP_END  = 10'h100,
      ST_RS_LOW    = 10'h200
   } state_type;

   // Kind of byte in the shifter
   typedef enum logic [3:0] {
      K_ADDR = 4'h1,
      K_INTERNAL_ADDRESS_BYTES = 4'h2,
      K_TX   = 4'h4,
      K_RX   = 4'h8
   } kind_type;

endpackage : two_wire_pkg

// file: testbench/bus_slave_model.sv
// Behavioural slave on the two-wire bus: acknowledges writes, serves reads
module bus_slave_model (
   // Bus line levels
   input wire logic scl,
   input wire logic sda,
   // Behaviour
   input wire logic ack_en,
   input wire logic [7:0] rd_data,
   // Data line pull, received byte with its ack bit, STOP count
   output logic pull,
   output logic [8:0] got,
   output logic got_stb,
   output int stops
);
   timeunit 1ns;
   timeprecision 1ns;
   int bitn = -1;
   logic rd = 1'b0;
   logic first = 1'b0;
   logic [7:0] sh = 8'h00;
   initial begin
      pull = 1'b0;
      got = 9'h000;
      got_stb = 1'b0;
      stops = 0;
   end
   // START and STOP are data edges while the clock is high
   always @(negedge sda) if (scl === 1'b1) begin
      bitn = -1;
      rd = 1'b0;
      first = 1'b1;
   end
   always @(posedge sda) if (scl === 1'b1) stops = stops + 1;
   // Sample MSB first on rising clock; ninth pulse carries the ack
   always @(posedge scl) begin
      if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
      if (bitn == 8) begin
         got = {sh, sda};
         if (first) rd = sh[0];
         else if (rd && sda) rd = 1'b0; // A refused byte ends our sending
         first = 1'b0;
         got_stb = 1'b1;
         #10 got_stb = 1'b0;
      end
   end
   // Change only on falling clock; a released line floats up to one
   always @(negedge scl) begin
      bitn = (bitn == 8) ? 0 : bitn + 1;
      if (bitn == 8) pull = !rd && ack_en;
      else pull = rd && !first && !rd_data[7 - bitn];
   end
endmodule : bus_slave_model

// file: testbench/two_wire_bus_master_tb_top.sv
// Self-checking bench of the two-wire bus master against a slave model
module two_wire_bus_master_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic men = 1'b0, start = 1'b0, stop = 1'b0, wr = 1'b0, rdir = 1'b0;
   logic rhr_rd = 1'b0, st_rd = 1'b0, ack_en = 1'b1;
   logic scl_oe, sda_oe, pull, stb, irq, dtx, drx;
   logic [6:0] adr = 7'h00;
   logic [1:0] iasz = 2'h0;
   logic [23:0] iab = 24'h000000;
   logic [7:0] d = 8'h00, rd_b = 8'h00, rhr;
   logic [8:0] got;
   logic [8:0] expq[$];
   two_wire_pkg::status_type st;
   two_wire_pkg::status_type ien = 4'h0;
   two_wire_pkg::clock_cfg_type cfg = 19'h00000; // 400 ns phases
   int bad_count = 0, n_checks = 0, seed = 39, cyc = 0, stops, s0, k;
   // Open-drain lines with pull-ups
   wire scl = !scl_oe;
   wire sda = !(sda_oe || pull);
   always #50 mclk = !mclk;
   two_wire_bus_master u_two_wire_bus_master (.mclk(mclk), .rst_n(rst_n),
      .serial_clock_pin_in(scl), .serial_clock_pin_out(),
      .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda),
      .serial_data_pin_out(), .serial_data_pin_oe(sda_oe),
      .master_enable_cmd(men), .master_disable_cmd(1'b0),
      .start_cmd(start), .stop_cmd(stop), .target_device_address(adr),
      .read_direction_bit(rdir), .internal_address_size(iasz),
      .internal_address_bytes(iab), .clock_cfg(cfg),
      .thr_data(d), .thr_write(wr), .rhr_data(rhr), .rhr_read(rhr_rd),
      .status(st), .status_read(st_rd), .irq_enable(ien), .irq(irq),
      .dma_tx_req(dtx), .dma_rx_req(drx));
   bus_slave_model u_bus_slave_model (.scl(scl), .sda(sda),
      .ack_en(ack_en), .rd_data(rd_b), .pull(pull), .got(got),
      .got_stb(stb), .stops(stops));
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   // Bounded wait: 0 for idle, 1 for transmit slot free, 2 for byte waiting
   task automatic wait_for(input int which);
      int i;
      @(negedge mclk);
      for (i = 0; i < 4000; i++) begin
         @(negedge mclk);
         if (which == 0 && st.tx_complete === 1'b1) break;
         if (which == 1 && st.transmit_slot_free === 1'b1) break;
         if (which == 2 && st.receive_byte_waiting === 1'b1) break;
      end
      chk(9'(i < 4000), 9'h001);
   endtask : wait_for
   // Note the expected byte, then write it to the holding register
   task automatic send(input logic [8:0] e);
      expq.push_back(e);
      d = e[8:1];
      wr = 1'b1;
      @(negedge mclk) wr = 1'b0;
   endtask : send
   ////////////////////////////////////////////////////////////////////////
   // Each byte seen on the wire retires the oldest expectation
   always @(posedge stb) begin
      if (expq.size() == 0) chk(got, ~got);
      else chk(got, expq.pop_front());
   end
   // Hang guard, far above the five transfers
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      chk(9'({st, dtx}), 9'h013);
      men = 1'b1;
      @(negedge mclk) men = 0;
      // Two-byte write, STOP only once the last byte sits in the shifter
      adr = 7'($random(seed));
      s0 = stops;
      expq.push_back({adr, 1'b0, 1'b0});
      send({8'($random(seed)), 1'b0});
      chk(9'({st.transmit_slot_free, dtx}), 9'h000);
      wait_for(1);
      send({8'($random(seed)), 1'b0});
      wait_for(1);
      repeat (300) @(negedge mclk);
      chk(9'(scl), 9'h000);
      stop = 1'b1;
      @(negedge mclk) stop = 1'b0;
      wait_for(0);
      chk(9'(stops - s0), 9'h001);
      $display("write test done");
      // Refused address: flag, interrupt, STOP, cleared by status read
      ack_en = 1'b0;
      ien = 4'h4;
      s0 = stops;
      expq.push_back({adr, 1'b0, 1'b1});
      d = 8'($random(seed));
      wr = 1'b1;
      @(negedge mclk) wr = 1'b0;
      wait_for(0);
      chk(9'({st.nack, irq}), 9'h003);
      chk(9'(stops - s0), 9'h001);
      st_rd = 1'b1;
      @(negedge mclk) st_rd = 1'b0;
      chk(9'({st.nack, irq}), 9'h000);
      $display("nack test done");
      // Reads: one byte; one byte from a ten-bit slave through an extra
      // address byte and repeated START; two bytes with the first left
      // unread, so the clock must stall before the last bit
      ack_en = 1'b1;
      rdir = 1'b1;
      iab = 24'($random(seed));
      for (k = 0; k < 3; k++) begin
         iasz = 2'(k == 1);
         rd_b = 8'($random(seed));
         if (k == 1) begin
            adr = {5'h1E, 2'($random(seed))};
            expq.push_back({adr, 1'b0, 1'b0});
            expq.push_back({iab[7:0], 1'b0});
         end
         expq.push_back({adr, 1'b1, 1'b0});
         if (k == 2) expq.push_back({rd_b, 1'b0});
         expq.push_back({rd_b, 1'b1});
         start = 1'b1;
         stop = (k < 2);
         @(negedge mclk) start = 1'b0;
         stop = 1'b0;
         if (k == 2) begin
            wait_for(2);
            stop = 1'b1;
            @(negedge mclk) stop = 1'b0;
            repeat (150) @(negedge mclk);
            chk(9'({scl, rhr == rd_b}), 9'h001);
            rhr_rd = 1'b1;
            @(negedge mclk) rhr_rd = 1'b0;
         end
         wait_for(0);
         chk({rhr, drx}, {rd_b, 1'b1});
         rhr_rd = 1'b1;
         @(negedge mclk) rhr_rd = 1'b0;
         @(negedge mclk);
         chk(9'({st.receive_byte_waiting, drx}), 9'h000);
      end
      chk(9'(expq.size()), 9'h000);
      $display("read test done");
      report_and_stop();
   end
endmodule : two_wire_bus_master_tb_top
